// ===== design/portc_mux_pkg.sv
// constants and types shared by the port C alternate-function mux
// assumes a single 250 MHz system clock domain
`default_nettype none
package portc_mux_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PORTC_WIDTH = 8;
  localparam int CRYSTAL_PINS = 2;
  localparam int SYNC_STAGES = 2;
  // register reset values
  localparam logic [7:0] ALT_FUNC_SELECT_LOW_RST = 8'h00;
  localparam logic [7:0] ALT_FUNC_SELECT_HIGH_RST = 8'h00;
  localparam logic [7:0] ALT_FUNC_ENABLE_RST = 8'h00;
  // field positions within port C, and the crystal output bit within port A
  localparam int PC_ANALOG_FOUR = 0;
  localparam int PC_ANALOG_FIVE = 1;
  localparam int PC_ANALOG_SIX = 2;
  localparam int PC_COMPARE_OUT = 3;
  localparam int PA_CRYSTAL_OUT = 1;
  // interrupt vector slots
  localparam logic [15:0] PORTC0_EDGE_VECTOR = 16'h0036;
  localparam logic [15:0] RESERVED_VECTOR = 16'h0038;
  // level that marks the debug condition on the shared debug pin
  localparam logic DEBUG_PRESENT_LEVEL = 1'b1;
  // cycles after reset release before the debug pin is judged (sync latency)
  localparam logic [1:0] DEBUG_SETTLE_CYCLES = 2'h2;
  typedef enum logic [1:0] {
    PKG_8PIN = 2'b00,
    PKG_20PIN = 2'b01,
    PKG_28PIN = 2'b10
  } pkg_variant_t;
  typedef enum logic [1:0] {
    DBG_SETTLE = 2'b00,
    DBG_ACTIVE = 2'b01,
    DBG_OFF = 2'b10
  } dbg_state_t;
endpackage : portc_mux_pkg
`default_nettype wire

// ===== design/port_c_alternate_function_mux.sv
// port C alternate-function mux with crystal override, external clock routing,
// shared debug pin fallback and the port C pin 0 both-edge interrupt
// assumes pin inputs are asynchronous and oscillator/comparator inputs are on i_clk
`default_nettype none
module port_c_alternate_function_mux
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_wr_select_low,
  input wire logic i_wr_select_high,
  input wire logic i_wr_alt_enable,
  input wire logic [7:0] i_wdata,
  input wire logic [1:0] i_pkg_variant,
  input wire logic i_xtal_enable,
  input wire logic i_external_clock_input_alt_select,
  input wire logic [portc_mux_pkg::CRYSTAL_PINS-1:0] i_porta_gp_out,
  input wire logic [portc_mux_pkg::CRYSTAL_PINS-1:0] i_porta_gp_oen,
  input wire logic i_crystal_out_pin,
  input wire logic i_ext_clock_pin_wide_pkg,
  input wire logic [portc_mux_pkg::PORTC_WIDTH-1:0] i_portc_pins,
  input wire logic i_comparator_result_out,
  input wire logic i_debug_pin,
  output logic [7:0] o_alt_func_select_low,
  output logic [7:0] o_alt_func_select_high,
  output logic [7:0] o_alt_func_enable,
  output logic [portc_mux_pkg::CRYSTAL_PINS-1:0] o_porta_pad_out,
  output logic [portc_mux_pkg::CRYSTAL_PINS-1:0] o_porta_pad_oen,
  output logic o_external_clock_input,
  output logic [2:0] o_portc_analog_connect,
  output logic o_vref_connect,
  output logic [portc_mux_pkg::PORTC_WIDTH-1:0] o_led_drive_en,
  output logic o_comparator_plus_in,
  output logic o_comparator_minus_in,
  output logic o_portc_line3_oen,
  output logic o_portc_line3_out,
  output logic o_portc0_irq,
  output logic [15:0] o_portc0_irq_vector,
  output logic o_debug_enabled,
  output logic o_debug_pin_gpio
);
  import portc_mux_pkg::*;

  typedef struct packed {
    logic [7:0] sel_low;
    logic [7:0] sel_high;
    logic [7:0] alt_en;
    logic [1:0] pkg_s1;
    logic [1:0] pkg_s2;
    logic [2:0] pc_s1;
    logic [2:0] pc_s2;
    logic pc0_prev;
    logic pb3_s1;
    logic pb3_s2;
    logic pa1_s1;
    logic pa1_s2;
    logic dbg_s1;
    logic dbg_s2;
    dbg_state_t dbg_state;
    logic [1:0] dbg_cnt;
    logic ext_clk;
    logic cmp_plus;
    logic cmp_minus;
    logic pc3_out;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [7:0] effective;

  // an alternate function other than the line 3 comparator output counts only when both select and enable are set
  function automatic logic [7:0] alt_active(input logic [7:0] sel, input logic [7:0] en);
    alt_active = sel & en;
  endfunction : alt_active

  assign effective = alt_active(state_reg.sel_low, state_reg.alt_en);

  always_comb begin
    state_next = state_reg;
    if (i_wr_select_low) begin
      state_next.sel_low = i_wdata;
    end
    // the high select register has no path into any mux below
    if (i_wr_select_high) begin
      state_next.sel_high = i_wdata;
    end
    if (i_wr_alt_enable) begin
      state_next.alt_en = i_wdata;
    end
    state_next.pkg_s1 = i_pkg_variant;
    state_next.pkg_s2 = state_reg.pkg_s1;
    state_next.pc_s1 = i_portc_pins[2:0];
    state_next.pc_s2 = state_reg.pc_s1;
    state_next.pc0_prev = state_reg.pc_s2[PC_ANALOG_FOUR];
    state_next.pb3_s1 = i_ext_clock_pin_wide_pkg;
    state_next.pb3_s2 = state_reg.pb3_s1;
    state_next.pa1_s1 = i_crystal_out_pin;
    state_next.pa1_s2 = state_reg.pa1_s1;
    state_next.dbg_s1 = i_debug_pin;
    state_next.dbg_s2 = state_reg.dbg_s1;
    // clock source depends on package; wide packages need the alternate selected
    if (pkg_variant_t'(state_reg.pkg_s2) == PKG_8PIN) begin
      state_next.ext_clk = state_reg.pa1_s2;
    end else begin
      state_next.ext_clk = i_external_clock_input_alt_select & state_reg.pb3_s2;
    end
    state_next.cmp_plus = effective[PC_ANALOG_FOUR] & state_reg.pc_s2[PC_ANALOG_FOUR];
    state_next.cmp_minus = effective[PC_ANALOG_FIVE] & state_reg.pc_s2[PC_ANALOG_FIVE];
    state_next.pc3_out = i_comparator_result_out;
    state_next.irq = state_reg.pc_s2[PC_ANALOG_FOUR] ^ state_reg.pc0_prev;
    // debug condition is judged once, after the synchroniser has filled
    case (state_reg.dbg_state)
      DBG_SETTLE: begin
        if (state_reg.dbg_cnt == DEBUG_SETTLE_CYCLES) begin
          if (state_reg.dbg_s2 == DEBUG_PRESENT_LEVEL) begin
            state_next.dbg_state = DBG_ACTIVE;
          end else begin
            state_next.dbg_state = DBG_OFF;
          end
        end else begin
          state_next.dbg_cnt = state_reg.dbg_cnt + 2'h1;
        end
      end
      DBG_ACTIVE: begin
        state_next.dbg_state = DBG_ACTIVE;
      end
      DBG_OFF: begin
        // only a reset leaves this state
        state_next.dbg_state = DBG_OFF;
      end
      default: begin
        state_next.dbg_state = DBG_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= '0;
      state_reg.sel_low <= ALT_FUNC_SELECT_LOW_RST;
      state_reg.sel_high <= ALT_FUNC_SELECT_HIGH_RST;
      state_reg.alt_en <= ALT_FUNC_ENABLE_RST;
      state_reg.dbg_state <= DBG_SETTLE;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign o_alt_func_select_low = state_reg.sel_low;
  assign o_alt_func_select_high = state_reg.sel_high;
  assign o_alt_func_enable = state_reg.alt_en;
  // crystal owns both pads: gpio drive is released and data forced low
  assign o_porta_pad_oen = i_xtal_enable ? {CRYSTAL_PINS{1'b1}} : i_porta_gp_oen;
  assign o_porta_pad_out = i_xtal_enable ? {CRYSTAL_PINS{1'b0}} : i_porta_gp_out;
  assign o_external_clock_input = state_reg.ext_clk;
  assign o_portc_analog_connect = effective[2:0];
  assign o_vref_connect = effective[PC_ANALOG_SIX] & (pkg_variant_t'(state_reg.pkg_s2) == PKG_20PIN);
  assign o_led_drive_en = effective;
  assign o_comparator_plus_in = state_reg.cmp_plus;
  assign o_comparator_minus_in = state_reg.cmp_minus;
  assign o_portc_line3_oen = ~(state_reg.alt_en[PC_COMPARE_OUT] & ~state_reg.sel_low[PC_COMPARE_OUT]);
  assign o_portc_line3_out = state_reg.pc3_out;
  assign o_portc0_irq = state_reg.irq;
  assign o_portc0_irq_vector = PORTC0_EDGE_VECTOR;
  assign o_debug_enabled = (state_reg.dbg_state == DBG_ACTIVE);
  assign o_debug_pin_gpio = (state_reg.dbg_state == DBG_OFF);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_XTAL_RELEASE: assert property (i_xtal_enable |-> (o_porta_pad_oen == 2'h3 && o_porta_pad_out == 2'h0))
    else $error("crystal pins still driven by gpio");
  AST_XTAL_PASS: assert property (!i_xtal_enable |-> o_porta_pad_oen == i_porta_gp_oen)
    else $error("gpio enable not passed when crystal off");
  AST_CLK_NARROW: assert property ((i_ce && pkg_variant_t'(state_reg.pkg_s2) == PKG_8PIN) |=>
      o_external_clock_input == $past(state_reg.pa1_s2))
    else $error("8-pin clock not from crystal_out_pin");
  AST_CLK_WIDE: assert property ((i_ce && pkg_variant_t'(state_reg.pkg_s2) != PKG_8PIN && !i_external_clock_input_alt_select)
      |=> !o_external_clock_input)
    else $error("wide clock passed without alternate select");
  AST_ALT_GATED: assert property (o_led_drive_en == (o_alt_func_select_low & o_alt_func_enable))
    else $error("alternate function active without enable");
  AST_VREF_PKG: assert property (o_vref_connect |-> (pkg_variant_t'(state_reg.pkg_s2) == PKG_20PIN
      && o_portc_analog_connect[2]))
    else $error("reference offered outside 20-pin part");
  AST_HIGH_INERT: assert property ((i_ce && i_wr_select_high && !i_wr_select_low && !i_wr_alt_enable)
      |=> $stable(o_led_drive_en))
    else $error("high select write changed routing");
  // the pulse is one cycle wide, so it must follow the synchronised change at once
  AST_IRQ_EDGE: assert property ((i_ce && $changed(state_reg.pc_s2[0])) |=> o_portc0_irq)
    else $error("pin 0 edge gave no interrupt");
  AST_IRQ_QUIET: assert property ((i_ce && state_reg.pc_s2[0] == state_reg.pc0_prev) |=> !o_portc0_irq)
    else $error("interrupt without a line 0 edge");
  AST_IRQ_VECTOR: assert property (o_portc0_irq_vector == PORTC0_EDGE_VECTOR)
    else $error("wrong interrupt vector");
  // a low enable must hold every register, writes and debug decision alike
  AST_CE_FREEZE: assert property (!i_ce |=> ($stable(o_alt_func_select_low) && $stable(o_debug_enabled)))
    else $error("state moved while clock enable low");
  AST_DBG_STICKY: assert property (o_debug_pin_gpio |=> o_debug_pin_gpio && !o_debug_enabled)
    else $error("debug came back without reset");
  AST_PC3_COMP: assert property ((o_alt_func_enable[3] && !o_alt_func_select_low[3]) |->
      (!o_portc_line3_oen && !o_led_drive_en[3]))
    else $error("line 3 comparator route wrong");

  COV_XTAL: cover property (i_xtal_enable ##1 !i_xtal_enable);
  COV_IRQ: cover property (o_portc0_irq ##[1:20] o_portc0_irq);
  COV_DBG_OFF: cover property (o_debug_pin_gpio);
  COV_VREF: cover property (o_vref_connect);
endmodule : port_c_alternate_function_mux
`default_nettype wire

// ===== testbench/port_c_alternate_function_mux_tb.sv
// self-checking bench for the port C alternate-function mux
// assumes the design package is compiled first; the bench drives every port itself
`default_nettype none
module port_c_alternate_function_mux_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import portc_mux_pkg::*;
  logic i_clk, i_rstn, i_ce, i_wr_select_low, i_wr_select_high, i_wr_alt_enable, i_xtal_enable;
  logic i_external_clock_input_alt_select, i_crystal_out_pin, i_ext_clock_pin_wide_pkg, i_comparator_result_out, i_debug_pin;
  logic [7:0] i_wdata, i_portc_pins, o_alt_func_select_low, o_alt_func_select_high, o_alt_func_enable;
  logic [7:0] o_led_drive_en;
  logic [1:0] i_pkg_variant, i_porta_gp_out, i_porta_gp_oen, o_porta_pad_out, o_porta_pad_oen;
  logic [2:0] o_portc_analog_connect;
  logic o_external_clock_input, o_vref_connect, o_comparator_plus_in, o_comparator_minus_in;
  logic o_portc_line3_oen, o_portc_line3_out, o_portc0_irq, o_debug_enabled, o_debug_pin_gpio;
  logic [15:0] o_portc0_irq_vector;
  int miscompares, n_tests, pulses;
  port_c_alternate_function_mux dut (.i_clk, .i_rstn, .i_ce, .i_wr_select_low, .i_wr_select_high,
    .i_wr_alt_enable, .i_wdata, .i_pkg_variant, .i_xtal_enable, .i_external_clock_input_alt_select, .i_porta_gp_out,
    .i_porta_gp_oen, .i_crystal_out_pin, .i_ext_clock_pin_wide_pkg, .i_portc_pins, .i_comparator_result_out,
    .i_debug_pin, .o_alt_func_select_low, .o_alt_func_select_high, .o_alt_func_enable, .o_porta_pad_out,
    .o_porta_pad_oen, .o_external_clock_input, .o_portc_analog_connect, .o_vref_connect, .o_led_drive_en,
    .o_comparator_plus_in, .o_comparator_minus_in, .o_portc_line3_oen, .o_portc_line3_out, .o_portc0_irq,
    .o_portc0_irq_vector, .o_debug_enabled, .o_debug_pin_gpio);
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // sample a little after the edge so registered outputs have settled
  task probe(input int n);
    cyc(n);
    #1;
  endtask : probe
  // which = {alt_enable, select_high, select_low} strobes, one cycle wide
  task wr(input logic [2:0] which, input logic [7:0] d);
    @(posedge i_clk);
    {i_wr_alt_enable, i_wr_select_high, i_wr_select_low} <= which;
    i_wdata <= d;
    @(posedge i_clk);
    {i_wr_alt_enable, i_wr_select_high, i_wr_select_low} <= 3'h0;
    #1;
  endtask : wr
  // drive port C pads and count interrupt pulses over a window longer than the sync path
  task pads(input logic [7:0] p, input int exp);
    cyc(1);
    i_portc_pins <= p;
    pulses = 0;
    repeat (8) begin
      probe(1);
      if (o_portc0_irq === 1'b1) pulses++;
    end
    chk(pulses, exp);
  endtask : pads
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  initial begin
    {i_rstn, i_wr_select_low, i_wr_select_high, i_wr_alt_enable, i_xtal_enable, i_external_clock_input_alt_select} = '0;
    {i_crystal_out_pin, i_ext_clock_pin_wide_pkg, i_comparator_result_out, i_debug_pin} = '0;
    {i_wdata, i_portc_pins, i_porta_gp_out, i_porta_gp_oen} = '0;
    i_pkg_variant = 2'h1;
    i_ce = 1'b1;
    cyc(4);
    i_rstn <= 1'b1;
    probe(1);
    chk(o_alt_func_select_low, 16'h0000);
    chk(o_alt_func_enable, 16'h0000);
    chk(o_portc_line3_oen, 16'h0001);
    chk(o_portc0_irq_vector, 16'h0036);
    probe(8);
    chk(o_debug_pin_gpio, 16'h0001);
    chk(o_debug_enabled, 16'h0000);
    cyc(1);
    i_debug_pin <= 1'b1;
    probe(8);
    chk(o_debug_pin_gpio, 16'h0001);
    cyc(1);
    i_porta_gp_out <= 2'h2;
    i_porta_gp_oen <= 2'h1;
    probe(1);
    chk(o_porta_pad_out, 16'h0002);
    chk(o_porta_pad_oen, 16'h0001);
    cyc(1);
    i_xtal_enable <= 1'b1;
    probe(1);
    chk(o_porta_pad_out, 16'h0000);
    chk(o_porta_pad_oen, 16'h0003);
    wr(3'h1, 8'hFF);
    chk(o_alt_func_select_low, 16'h00FF);
    chk(o_led_drive_en, 16'h0000);
    chk(o_portc_analog_connect, 16'h0000);
    wr(3'h4, 8'hFF);
    chk(o_led_drive_en, 16'h00FF);
    chk(o_portc_analog_connect, 16'h0007);
    chk(o_portc_line3_oen, 16'h0001);
    wr(3'h1, 8'h07);
    chk(o_led_drive_en, 16'h0007);
    chk(o_portc_line3_oen, 16'h0000);
    i_comparator_result_out <= 1'b1;
    probe(3);
    chk(o_portc_line3_out, 16'h0001);
    chk(o_vref_connect, 16'h0001);
    wr(3'h2, 8'hF8);
    chk(o_alt_func_select_high, 16'h00F8);
    chk(o_led_drive_en, 16'h0007);
    chk(o_portc_analog_connect, 16'h0007);
    wr(3'h1, 8'h03);
    chk(o_portc_analog_connect, 16'h0003);
    chk(o_vref_connect, 16'h0000);
    pads(8'h01, 1);
    chk(o_comparator_plus_in, 16'h0001);
    pads(8'h03, 0);
    chk(o_comparator_minus_in, 16'h0001);
    pads(8'h02, 1);
    wr(3'h1, 8'h07);
    i_pkg_variant <= 2'h2;
    i_ext_clock_pin_wide_pkg <= 1'b1;
    probe(6);
    chk(o_vref_connect, 16'h0000);
    chk(o_external_clock_input, 16'h0000);
    i_external_clock_input_alt_select <= 1'b1;
    probe(5);
    chk(o_external_clock_input, 16'h0001);
    i_pkg_variant <= 2'h0;
    i_ext_clock_pin_wide_pkg <= 1'b0;
    i_crystal_out_pin <= 1'b1;
    probe(6);
    chk(o_external_clock_input, 16'h0001);
    i_ext_clock_pin_wide_pkg <= 1'b1;
    i_crystal_out_pin <= 1'b0;
    probe(6);
    chk(o_external_clock_input, 16'h0000);
    // a write strobed while the clock enable is low must be ignored
    cyc(1);
    i_ce <= 1'b0;
    wr(3'h1, 8'h00);
    chk(o_alt_func_select_low, 16'h0007);
    chk(o_led_drive_en, 16'h0007);
    i_ce <= 1'b1;
    i_rstn <= 1'b0;
    cyc(4);
    i_rstn <= 1'b1;
    probe(8);
    chk(o_debug_enabled, 16'h0001);
    chk(o_debug_pin_gpio, 16'h0000);
    complete_run();
  end
endmodule : port_c_alternate_function_mux_tb
`default_nettype wire
